// >>> verilog/program_flash_read_port.sv
// The address map and register access over Wishbone were decided locally.
`default_nettype none

// Overview of operation
// R1: Word address is address-high register concatenated above address-low register.
// R2: Writing one to control bit 0 starts a program memory read.
// R3: A read lasts two instruction cycles; the core is stalled meanwhile.
// R4: Software should put two no-ops after setting the read bit.
// R5: Finished word loads upper bits into data-high, lower into data-low.
// R6: Read bit cleared only by hardware; software writing zero does nothing.
// R7: Data-high holds word bits 13..8 in bits 5..0; top two read zero.
// R8: Data-low holds word bits 7..0 and is software readable and writable.
// R9: Control bit 7 reads one; bits 6..1 read zero.
// R10: Reads proceed and return the true word regardless of code protection.
// R11: Read bit clears in the same cycle the data pair loads.
// R12: Address and data registers change only by software or read completion.
module program_flash_read_port
  import prog_mem_read_pkg::*;
#(
  parameter int unsigned CLKS_INSTR = CLKS_PER_INSTR,
  parameter int unsigned READ_INSTR = INSTR_PER_READ
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Classic Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [WB_ADR_W-1:0]     wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [WB_DATA_W-1:0]    wb_dat_i,
  output logic      [WB_DATA_W-1:0]    wb_dat_o,
  output logic                         wb_ack_o,
  // Flash array side
  output logic      [FLASH_ADDR_W-1:0] flash_addr_o,
  output logic                         flash_rd_o,
  input  wire logic [WORD_W-1:0]       flash_data_i,
  // Core side
  output logic                         core_stall_o
);

  localparam int READ_CLKS = int'(CLKS_INSTR * READ_INSTR);

  if (CLKS_INSTR < 1 || READ_INSTR < 1) begin : g_chk
    $error("program_flash_read_port: timing parameters must be at least one");
  end

  read_state_type              state_q;
  logic [WB_DATA_W-1:0]        dat_q;
  logic                        ack_q;
  logic [REG_W-1:0]            addr_low_q;
  logic [REG_W-1:0]            addr_high_q;
  logic [LOW_W-1:0]            data_low_q;
  logic [HIGH_W-1:0]           data_high_q;
  logic [FLASH_ADDR_W-1:0]     flash_addr_q;
  logic                        stall_q;
  logic                        req;
  logic                        wr_go;
  logic                        set_rd;
  logic                        tick;
  logic                        done;
  logic [REG_W-1:0]            rd_mux;
  logic [REG_W-1:0]            wr_byte;

  assign req     = wb_cyc_i && wb_stb_i;
  assign wr_byte = wb_dat_i[REG_W-1:0];
  // Writes take effect at the edge the master samples ack
  assign wr_go   = req && ack_q && wb_we_i && wb_sel_i[0];
  // Only a one can be written to the read bit
  assign set_rd  = wr_go && (wb_adr_i == OFS_CONTROL) && wr_byte[RD_BIT]; // R2 R6

  // Instruction-cycle enable, realigned at every read start
  instr_tick_gen #(
    .DIV (CLKS_INSTR)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .clr_i  (set_rd),
    .tick_o (tick)
  );

  // Counts the two instruction cycles of the array access
  read_cycle_counter #(
    .COUNT (READ_INSTR)
  ) u_count (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (set_rd),
    .tick_i  (tick),
    .done_o  (done)
  );

  // Read controller; a new set on the finishing edge wins and restarts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (set_rd) begin
            state_q <= ST_BUSY; // R2
          end
        end
        ST_BUSY: begin
          if (done && !set_rd) begin
            state_q <= ST_IDLE; // R6 R11
          end
        end
      endcase
    end
  end

  // Core stall follows the read bit: the two next instructions are not run
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stall_q <= 1'b0;
    end else if (set_rd) begin
      stall_q <= 1'b1; // R3
    end else if (done) begin
      stall_q <= 1'b0; // R3
    end
  end

  // Word address latched at start so later address writes cannot disturb it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_addr_q <= '0;
    end else if (set_rd) begin
      flash_addr_q <= {addr_high_q, addr_low_q}; // R1
    end
  end

  // Address pair, written only by software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_low_q  <= ADDR_RESET;
      addr_high_q <= ADDR_RESET;
    end else if (wr_go) begin
      if (wb_adr_i == OFS_ADDR_LOW) begin
        addr_low_q <= wr_byte; // R12
      end
      if (wb_adr_i == OFS_ADDR_HIGH) begin
        addr_high_q <= wr_byte; // R12
      end
    end
  end

  // Data pair; the hardware load beats a software write on the same edge.
  // No protection input exists, so the fetched word is loaded untouched.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_low_q  <= DATA_LOW_RESET;
      data_high_q <= DATA_HIGH_RESET;
    end else if (done) begin
      data_low_q  <= flash_data_i[LOW_W-1:0];      // R5 R10 R11
      data_high_q <= flash_data_i[WORD_W-1:LOW_W]; // R5 R7 R10 R11
    end else if (wr_go) begin
      if (wb_adr_i == OFS_DATA_LOW) begin
        data_low_q <= wr_byte; // R8 R12
      end
      if (wb_adr_i == OFS_DATA_HIGH) begin
        data_high_q <= wr_byte[HIGH_W-1:0]; // R7 R12
      end
    end
  end

  // Read-back mux; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      OFS_CONTROL: begin
        rd_mux = CONTROL_FIXED; // R9
        rd_mux[RD_BIT] = (state_q == ST_BUSY);
      end
      OFS_ADDR_LOW: begin
        rd_mux = addr_low_q;
      end
      OFS_ADDR_HIGH: begin
        rd_mux = addr_high_q;
      end
      OFS_DATA_LOW: begin
        rd_mux = data_low_q; // R8
      end
      OFS_DATA_HIGH: begin
        rd_mux = {{(REG_W - HIGH_W){1'b0}}, data_high_q}; // R7
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        dat_q <= {{(WB_DATA_W - REG_W){1'b0}}, rd_mux};
      end
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = dat_q;
  assign flash_addr_o = flash_addr_q;
  assign flash_rd_o   = (state_q == ST_BUSY);
  assign core_stall_o = stall_q;

  // Checks ------------------------------------------------------------------
  localparam int LAT     = READ_CLKS;
  localparam int LAT_M1  = READ_CLKS - 1;

  sequence s_start;
    set_rd && state_q == ST_IDLE;
  endsequence

  sequence s_busy_run;
    flash_rd_o && core_stall_o;
  endsequence

  property p_read_len;
    @(posedge clk_i) disable iff (rst_i)
      s_start |=> s_busy_run [*1] ##0 (flash_rd_o throughout (1'b1 ##[LAT_M1:LAT_M1] 1'b1))
        ##1 (!flash_rd_o || $past(set_rd));
  endproperty
  a_read_len: assert property (p_read_len) else $error("read length wrong"); // R3

  property p_addr_cat;
    @(posedge clk_i) disable iff (rst_i)
      set_rd |=> flash_addr_o == {$past(addr_high_q), $past(addr_low_q)};
  endproperty
  a_addr_cat: assert property (p_addr_cat) else $error("address not concatenated"); // R1

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
      done |=> data_low_q == $past(flash_data_i[LOW_W-1:0])
        && data_high_q == $past(flash_data_i[WORD_W-1:LOW_W]);
  endproperty
  a_load: assert property (p_load) else $error("data pair not loaded"); // R5

  property p_clear_with_load;
    @(posedge clk_i) disable iff (rst_i)
      $fell(flash_rd_o) |-> $past(done) && data_low_q == $past(flash_data_i[LOW_W-1:0]);
  endproperty
  a_clear_with_load: assert property (p_clear_with_load) else $error("bit cleared early"); // R11

  property p_no_sw_clear;
    @(posedge clk_i) disable iff (rst_i)
      flash_rd_o && !done |=> flash_rd_o;
  endproperty
  a_no_sw_clear: assert property (p_no_sw_clear) else $error("read bit lost"); // R6

  property p_ctrl_read;
    @(posedge clk_i) disable iff (rst_i)
      req && !ack_q && !wb_we_i && wb_adr_i == OFS_CONTROL
        |=> wb_ack_o && wb_dat_o[REG_W-1:1] == CONTROL_FIXED[REG_W-1:1];
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bits"); // R9

  property p_high_top;
    @(posedge clk_i) disable iff (rst_i)
      req && !ack_q && !wb_we_i && wb_adr_i == OFS_DATA_HIGH |=> wb_dat_o[7:6] == 2'h0;
  endproperty
  a_high_top: assert property (p_high_top) else $error("data-high top bits set"); // R7

  property p_data_stable;
    @(posedge clk_i) disable iff (rst_i)
      !done && !wr_go |=> $stable(data_low_q) && $stable(data_high_q)
        && $stable(addr_low_q) && $stable(addr_high_q);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("register changed idle"); // R12

  property p_low_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_go && !done && wb_adr_i == OFS_DATA_LOW |=> data_low_q == $past(wr_byte);
  endproperty
  a_low_write: assert property (p_low_write) else $error("data-low not writable"); // R8

  property p_start;
    @(posedge clk_i) disable iff (rst_i)
      set_rd |=> flash_rd_o ##[LAT_M1:LAT] !flash_rd_o || set_rd;
  endproperty
  a_start: assert property (p_start) else $error("read did not start"); // R2

  sequence s_ctrl_read;
    req && !ack_q && !wb_we_i && wb_adr_i == OFS_CONTROL;
  endsequence

  // A control read taken while the array is busy shows the bit set
  property p_busy_read;
    @(posedge clk_i) disable iff (rst_i)
      s_ctrl_read ##0 flash_rd_o |=> wb_dat_o[RD_BIT];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("read bit not shown busy"); // R2

  // Once the read is over the bit reads clear, so polling can stop
  property p_idle_read;
    @(posedge clk_i) disable iff (rst_i)
      s_ctrl_read ##0 !flash_rd_o |=> !wb_dat_o[RD_BIT];
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("read bit shown while idle"); // R11

  // Stall and read level must agree or the core runs into a live read
  property p_stall_match;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |-> core_stall_o == flash_rd_o;
  endproperty
  a_stall_match: assert property (p_stall_match) else $error("stall not matching read"); // R3

  // A zero written to the read bit while busy leaves the read running
  property p_zero_ignored;
    @(posedge clk_i) disable iff (rst_i)
      wr_go && wb_adr_i == OFS_CONTROL && !wr_byte[RD_BIT] && flash_rd_o && !done
        |=> flash_rd_o;
  endproperty
  a_zero_ignored: assert property (p_zero_ignored) else $error("zero write cleared bit"); // R6

  // The word address stands still while the array is being read
  property p_addr_hold;
    @(posedge clk_i) disable iff (rst_i)
      flash_rd_o && !set_rd |=> $stable(flash_addr_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved during read"); // R1

  // Data-high keeps only the six word bits of a software write
  property p_high_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_go && !done && wb_adr_i == OFS_DATA_HIGH
        |=> data_high_q == $past(wr_byte[HIGH_W-1:0]);
  endproperty
  a_high_write: assert property (p_high_write) else $error("data-high not writable"); // R7

  // No read starts unless software sets the bit
  property p_no_self_start;
    @(posedge clk_i) disable iff (rst_i)
      !flash_rd_o && !set_rd |=> !flash_rd_o;
  endproperty
  a_no_self_start: assert property (p_no_self_start) else $error("read began unasked"); // R2

  // Ack is a single-cycle pulse; a held request is answered again every other cycle
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

endmodule : program_flash_read_port

`default_nettype wire

// >>> verilog/prog_mem_read_pkg.sv
`default_nettype none

package prog_mem_read_pkg;

  // Bus geometry: one aligned 32-bit word per register, 8-bit data in lane 0
  localparam int unsigned WB_DATA_W      = 32;
  localparam int unsigned WB_ADR_W       = 5;
  localparam int unsigned REG_W          = 8;

  // Register byte offsets
  localparam logic [4:0]  OFS_CONTROL    = 5'h00;
  localparam logic [4:0]  OFS_ADDR_LOW   = 5'h04;
  localparam logic [4:0]  OFS_ADDR_HIGH  = 5'h08;
  localparam logic [4:0]  OFS_DATA_LOW   = 5'h0c;
  localparam logic [4:0]  OFS_DATA_HIGH  = 5'h10;

  // Control register layout
  localparam int unsigned RD_BIT         = 0;
  localparam logic [7:0]  CONTROL_FIXED  = 8'h80;

  // Program word layout
  localparam int unsigned WORD_W         = 14;
  localparam int unsigned LOW_W          = 8;
  localparam int unsigned HIGH_W         = WORD_W - LOW_W;
  localparam int unsigned FLASH_ADDR_W   = 16;

  // Reset values
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [7:0]  DATA_LOW_RESET = 8'h00;
  localparam logic [5:0]  DATA_HIGH_RESET = 6'h00;

  // Timing: a read lasts two instruction cycles of four clocks each
  localparam int unsigned INSTR_PER_READ = 2;
  localparam int unsigned CLKS_PER_INSTR = 4;

  // Read controller states
  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } read_state_type;

endpackage : prog_mem_read_pkg

`default_nettype wire

// >>> verilog/instr_tick_gen.sv
`default_nettype none

module instr_tick_gen #(
  parameter int unsigned DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clr_i,
  output logic      tick_o
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] cnt_q;

  if (DIV < 1) begin : g_chk
    $error("instr_tick_gen: DIV must be at least one");
  end

  // Phase counter; clearing it aligns instruction cycles to the read start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (clr_i || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + ONE;
    end
  end

  // One-cycle enable at the end of each instruction cycle
  assign tick_o = (cnt_q == LAST) && !clr_i;

endmodule : instr_tick_gen

`default_nettype wire

// >>> verilog/read_cycle_counter.sv
`default_nettype none

module read_cycle_counter #(
  parameter int unsigned COUNT = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic tick_i,
  output logic      done_o
);

  localparam int unsigned CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] INIT = CW'(COUNT);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] left_q;

  if (COUNT < 1) begin : g_chk
    $error("read_cycle_counter: COUNT must be at least one");
  end

  // Counts instruction cycles left; a new start reloads even mid-count
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      left_q <= '0;
    end else if (start_i) begin
      left_q <= INIT;
    end else if (tick_i && left_q != '0) begin
      left_q <= left_q - ONE;
    end
  end

  // Last tick of the final instruction cycle
  assign done_o = tick_i && !start_i && (left_q == ONE);

endmodule : read_cycle_counter

`default_nettype wire

// >>> verif/flash_array_model.sv
`default_nettype none

module flash_array_model
  import prog_mem_read_pkg::*;
(
  input  wire logic                    clk_i,
  input  wire logic                    rd_i,
  input  wire logic [FLASH_ADDR_W-1:0] addr_i,
  output logic      [WORD_W-1:0]       data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Word is a scramble of its address; no protection gate on the way out
  // Outside a read the bus inverts every cycle, so a late sample looks valid only on alternate cycles
  initial data_o = 14'h1555;
  always @(posedge clk_i) begin
    if (rd_i) begin
      data_o <= addr_i[13:0] ^ {addr_i[15:14], 12'ha5c};
    end else begin
      data_o <= ~data_o;
    end
  end
endmodule : flash_array_model

`default_nettype wire

// >>> verif/tb_program_flash_read_port.sv
`default_nettype none

module tb_program_flash_read_port
  import prog_mem_read_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        cyc = 1'h0;
  logic        stb = 1'h0;
  logic        we  = 1'h0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic        ack;
  logic [15:0] f_addr;
  logic        f_rd;
  logic [13:0] f_data;
  logic        stall;
  logic [15:0] seen_adr;
  int          run, last_run;
  int          n_mismatch, checked;

  always #4 clk = ~clk;

  program_flash_read_port #(.CLKS_INSTR(CLKS_PER_INSTR), .READ_INSTR(INSTR_PER_READ)) dut_u (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .flash_addr_o(f_addr), .flash_rd_o(f_rd),
    .flash_data_i(f_data), .core_stall_o(stall));

  flash_array_model flash_u (.clk_i(clk), .rd_i(f_rd), .addr_i(f_addr), .data_o(f_data));

  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk_reg

  task automatic chk_cnt(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0d got %0d", nm, e, g);
    end
  endtask : chk_cnt

  // One classic cycle; entered just after an edge, leaves one idle cycle
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    cyc   <= 1'h1;
    stb   <= 1'h1;
    we    <= w;
    adr   <= a;
    dat_w <= ($urandom() & 32'hffffff00) | {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    chk_cnt("ack_seen", 1, int'(ack === 1'h1));
    q = dat_r;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask : bus

  function automatic logic [13:0] exp_word(input logic [15:0] a);
    return a[13:0] ^ {a[15:14], 12'ha5c};
  endfunction : exp_word

  // Stall run length and the address shown while it lasts
  always @(posedge clk) begin
    chk_reg("rd_vs_stall", {31'h0, stall}, {31'h0, f_rd});
    if (stall === 1'h1) begin
      run++;
      seen_adr = f_addr;
    end else if (run != 0) begin
      last_run = run;
      run = 0;
    end
  end

  task report_and_stop;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Whole run is a few hundred cycles; this cuts a hung handshake short
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [31:0] q;
    logic [15:0] a;
    logic [13:0] w;
    logic [7:0]  b;
    int          n;
    void'($urandom(32'h41c9bd5e));
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    bus(1'h0, OFS_CONTROL, 8'h00, q);
    chk_reg("control_rst", 32'h80, q);
    bus(1'h0, 5'h14, 8'h00, q);
    chk_reg("unmapped", 32'h0, q);
    b = 8'($urandom());
    bus(1'h1, OFS_DATA_LOW, b, q);
    bus(1'h0, OFS_DATA_LOW, 8'h00, q);
    chk_reg("data_low_rw", {24'h0, b}, q);
    // Lane 0 disabled: the write must not land
    sel <= 4'he;
    bus(1'h1, OFS_DATA_LOW, ~b, q);
    sel <= 4'hf;
    bus(1'h0, OFS_DATA_LOW, 8'h00, q);
    chk_reg("data_low_sel", {24'h0, b}, q);
    bus(1'h1, OFS_DATA_HIGH, 8'hff, q);
    bus(1'h0, OFS_DATA_HIGH, 8'h00, q);
    chk_reg("data_high_top", 32'h3f, q);
    // Corner addresses first, then random ones
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : 16'($urandom());
      bus(1'h1, OFS_ADDR_LOW, a[7:0], q);
      bus(1'h1, OFS_ADDR_HIGH, a[15:8], q);
      if (i > 0) begin
        bus(1'h0, OFS_DATA_LOW, 8'h00, q);
        chk_reg("data_low_held", {24'h0, w[7:0]}, q);
      end
      bus(1'h1, OFS_CONTROL, 8'h01, q);
      if (i == 2) begin
        bus(1'h1, OFS_CONTROL, 8'h00, q);
        bus(1'h0, OFS_CONTROL, 8'h00, q);
        chk_reg("control_busy", 32'h81, q);
      end
      n = 0;
      do begin
        bus(1'h0, OFS_CONTROL, 8'h00, q);
        n++;
      end while (q[0] !== 1'h0 && n < 20);
      w = exp_word(a);
      chk_reg("control_done", 32'h80, q);
      chk_reg("flash_addr", {16'h0, a}, {16'h0, seen_adr});
      chk_cnt("stall_cycles", int'(CLKS_PER_INSTR * INSTR_PER_READ), last_run);
      bus(1'h0, OFS_DATA_HIGH, 8'h00, q);
      chk_reg("data_high", {26'h0, w[13:8]}, q);
      bus(1'h0, OFS_DATA_LOW, 8'h00, q);
      chk_reg("data_low", {24'h0, w[7:0]}, q);
    end
    report_and_stop();
  end
endmodule : tb_program_flash_read_port

`default_nettype wire
